// ==== src/rdf_params.svh ====
/*
 Timing counts, register offsets, field positions and reset values for the diode-fault status block.
 Assumes it is included by bare name from the status module and the bench.
*/
`ifndef RDF_PARAMS_SVH
`define RDF_PARAMS_SVH

`define RDF_SLAVE_ADDR 7'h4D
`define RDF_NUM_CH 6
`define RDF_FAULT_LSB 1
`define RDF_FAULT_MSB 6
`define RDF_STATUS3_RESET 8'h00
`define RDF_STATUS3_OFFSET 8'h00
`define RDF_CFG2_OFFSET 8'h01
`define RDF_CFG3_OFFSET 8'h02
`define RDF_CONV_CYCLES 16'h0100

`endif

// ==== src/rdf_pkg.sv ====
/*
 Types shared by the diode-fault status block.
 Assumes rdf_params.svh sits in the include path.
*/
package rdf_pkg;
    typedef struct packed {
        logic [5:0] open_ckt;
        logic [5:0] tied_vcc;
    } rdf_sense_t;

    typedef enum logic [2:0] {
        RDF_IDLE,
        RDF_ADDR,
        RDF_ADDR_ACK,
        RDF_CMD,
        RDF_CMD_ACK,
        RDF_TX,
        RDF_TX_ACK,
        RDF_SKIP
    } rdf_state_t;
endpackage

// ==== src/rdf_sync.sv ====
/*
 Two-flop synchroniser with rise/fall detection on the second stage output.
 Assumes the input is asynchronous to mclk_i.
*/
`timescale 1ns/1ps
module rdf_sync (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // ==========================================================
    // Synchroniser.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~last_q;
    assign fall_o = ~sync_q & last_q;
endmodule // rdf_sync

// ==== src/rdf_status.sv ====
/*
 Diode-fault status register with its two-wire slave port and channel masks.
 Assumes analog detectors deliver fault levels, and the host drives the serial clock.
*/
// How it works
// - Flag for channel n sits at bit n of the status register for n from 1 to 6.
// - A channel whose sense inputs are open sets its flag.
// - A channel whose positive sense input is tied to the supply sets its flag.
// - The register resets to zero and bits 7 and 0 always read zero.
// - Only the address 1001101 in bits A7 to A1 is acknowledged.
// - Faulted channels are skipped by the measurement sequence.
// - Mask bits in configuration registers 2 and 3 keep a channel off the alert and overtemp outputs.
`timescale 1ns/1ps
`include "rdf_params.svh"
module rdf_status
    import rdf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire rdf_sense_t sense_i,
    input wire logic [5:0] alert_raw_i,
    input wire logic [5:0] overtemp_output_raw_i,
    output logic [7:0] fault_status_o,
    output logic [2:0] meas_ch_o,
    output logic meas_valid_o,
    output logic alert_n_o,
    output logic overtemp_output_n_o
);
    // ==========================================================
    // Input synchronisers.
    logic scl_s, scl_rise, scl_fall;
    logic sda_s, sda_rise, sda_fall;
    logic [5:0] open_meta_q, open_q, vcc_meta_q, vcc_q;

    rdf_sync u_scl (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i(scl_i),
        .level_o(scl_s),
        .rise_o(scl_rise),
        .fall_o(scl_fall)
    );

    rdf_sync u_sda (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i(sda_i),
        .level_o(sda_s),
        .rise_o(sda_rise),
        .fall_o(sda_fall)
    );

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            open_meta_q <= 6'h00;
            open_q <= 6'h00;
            vcc_meta_q <= 6'h00;
            vcc_q <= 6'h00;
        end else begin
            open_meta_q <= sense_i.open_ckt;
            open_q <= open_meta_q;
            vcc_meta_q <= sense_i.tied_vcc;
            vcc_q <= vcc_meta_q;
        end
    end

    // ==========================================================
    // Fault status register.
    logic [7:0] status_q, status_d;
    wire [5:0] fault_now = open_q | vcc_q;
    assign status_d = {1'b0, fault_now, 1'b0};

    // ==========================================================
    // Serial slave.
    rdf_state_t state_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q, ptr_q, cfg2_q, cfg3_q;
    logic rw_q, sda_o_q, sda_oe_q, first_data_q;
    wire start_seen = sda_fall & scl_s;
    wire stop_seen = sda_rise & scl_s;
    wire [7:0] shift_in = {shift_q[6:0], sda_s};
    wire [7:0] read_data = (ptr_q == `RDF_STATUS3_OFFSET) ? status_q :
                           (ptr_q == `RDF_CFG2_OFFSET) ? cfg2_q :
                           (ptr_q == `RDF_CFG3_OFFSET) ? cfg3_q : 8'h00;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= `RDF_STATUS3_RESET;
            state_q <= RDF_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            cfg2_q <= 8'h00;
            cfg3_q <= 8'h00;
            rw_q <= 1'b0;
            sda_o_q <= 1'b0;
            sda_oe_q <= 1'b0;
            first_data_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (start_seen) begin
                state_q <= RDF_ADDR;
                bit_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end else if (stop_seen) begin
                state_q <= RDF_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                unique case (state_q)
                    RDF_IDLE, RDF_SKIP: begin
                        sda_oe_q <= 1'b0;
                    end
                    RDF_ADDR: begin
                        if (scl_rise) begin
                            shift_q <= shift_in;
                            bit_q <= bit_q + 4'h1;
                        end
                        if (scl_fall && bit_q == 4'h8) begin
                            rw_q <= shift_q[0];
                            if (shift_q[7:1] == `RDF_SLAVE_ADDR) begin
                                sda_oe_q <= 1'b1;
                                state_q <= RDF_ADDR_ACK;
                            end else begin
                                state_q <= RDF_SKIP;
                            end
                        end
                    end
                    RDF_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_q <= 4'h0;
                            if (rw_q) begin
                                state_q <= RDF_TX;
                                sda_oe_q <= ~read_data[7];
                                shift_q <= {read_data[6:0], 1'b1};
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q <= RDF_CMD;
                                first_data_q <= 1'b1;
                            end
                        end
                    end
                    RDF_CMD: begin
                        if (scl_rise) begin
                            shift_q <= shift_in;
                            bit_q <= bit_q + 4'h1;
                        end
                        if (scl_fall && bit_q == 4'h8) begin
                            sda_oe_q <= 1'b1;
                            state_q <= RDF_CMD_ACK;
                            if (first_data_q) begin
                                ptr_q <= shift_q;
                            end else if (ptr_q == `RDF_CFG2_OFFSET) begin
                                cfg2_q <= shift_q;
                            end else if (ptr_q == `RDF_CFG3_OFFSET) begin
                                cfg3_q <= shift_q;
                            end
                            first_data_q <= 1'b0;
                        end
                    end
                    RDF_CMD_ACK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            bit_q <= 4'h0;
                            state_q <= RDF_CMD;
                        end
                    end
                    RDF_TX: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h7) begin
                                sda_oe_q <= 1'b0;
                                state_q <= RDF_TX_ACK;
                            end else begin
                                sda_oe_q <= ~shift_q[7];
                                shift_q <= {shift_q[6:0], 1'b1};
                            end
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    RDF_TX_ACK: begin
                        if (scl_rise) begin
                            state_q <= sda_s ? RDF_SKIP : RDF_TX_ACK;
                        end else if (scl_fall) begin
                            bit_q <= 4'h0;
                            state_q <= RDF_TX;
                            sda_oe_q <= ~read_data[7];
                            shift_q <= {read_data[6:0], 1'b1};
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Measurement sequencer and output masking.
    logic [15:0] conv_q;
    logic [2:0] ch_q, ch_next;
    logic valid_q, alert_n_q, overtemp_output_n_q;
    always_comb begin
        ch_next = ch_q;
        for (int k = 6; k >= 1; k--) begin
            if (!status_q[(32'(ch_q) + k) % 6 + 1]) begin
                ch_next = 3'((32'(ch_q) + k) % 6);
            end
        end
    end
    wire [5:0] alert_live = alert_raw_i & ~cfg2_q[5:0] & ~status_q[6:1];
    wire [5:0] overtemp_output_live = overtemp_output_raw_i & ~cfg3_q[5:0] & ~status_q[6:1];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_q <= 16'h0000;
            ch_q <= 3'h0;
            valid_q <= 1'b0;
            alert_n_q <= 1'b1;
            overtemp_output_n_q <= 1'b1;
        end else begin
            alert_n_q <= ~|alert_live;
            overtemp_output_n_q <= ~|overtemp_output_live;
            if (conv_q == `RDF_CONV_CYCLES - 16'h0001) begin
                conv_q <= 16'h0000;
                ch_q <= ch_next;
                valid_q <= ~status_q[32'(ch_next) + 1];
            end else begin
                conv_q <= conv_q + 16'h0001;
                valid_q <= valid_q & ~status_q[32'(ch_q) + 1];
            end
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe_o = sda_oe_q;
    assign fault_status_o = status_q;
    assign meas_ch_o = ch_q;
    assign meas_valid_o = valid_q;
    assign alert_n_o = alert_n_q;
    assign overtemp_output_n_o = overtemp_output_n_q;
endmodule // rdf_status

// ==== tb/rdf_status_checker.sv ====
/* Port assertions for the diode-fault status block.
 Assumes it is bound onto rdf_status. */
`timescale 1ns/1ps
module rdf_status_checker
    import rdf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire rdf_sense_t sense_i,
    input wire logic [5:0] alert_raw_i,
    input wire logic [5:0] overtemp_output_raw_i,
    input wire logic [7:0] fault_status_o,
    input wire logic [2:0] meas_ch_o,
    input wire logic meas_valid_o,
    input wire logic alert_n_o,
    input wire logic overtemp_output_n_o
);
    // ========================================
    // Checks.
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire [5:0] flt = fault_status_o[6:1];
    property p_flags; $stable(sense_i) [*6] |-> flt == (sense_i.open_ckt | sense_i.tied_vcc); endproperty
    a_flags: assert property (p_flags) else $error("flags");
    property p_resv; fault_status_o[7] == 1'b0 && fault_status_o[0] == 1'b0; endproperty
    a_resv: assert property (p_resv) else $error("reserved");
    property p_rst; $rose(rst_n_i) |-> fault_status_o == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_skip; meas_valid_o && $stable(flt) |-> !flt[meas_ch_o]; endproperty
    a_skip: assert property (p_skip) else $error("faulted measured");
    property p_chr; meas_ch_o <= 3'h5; endproperty
    a_chr: assert property (p_chr) else $error("channel range");
    property p_alrt; ((alert_raw_i & ~flt) == 6'h00) [*3] |-> alert_n_o; endproperty
    a_alrt: assert property (p_alrt) else $error("alert");
    property p_ovt; ((overtemp_output_raw_i & ~flt) == 6'h00) [*3] |-> overtemp_output_n_o; endproperty
    a_ovt: assert property (p_ovt) else $error("overtemp");
    property p_oe; $changed(sda_oe_o) |-> !scl_i; endproperty
    a_oe: assert property (p_oe) else $error("data moved");
    c_ack: cover property ($rose(sda_oe_o));
    c_flt: cover property (flt != 6'h00);
    c_meas: cover property (meas_valid_o);
endmodule // rdf_status_checker
bind rdf_status rdf_status_checker chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
    .sda_oe_o(sda_oe_o), .sense_i(sense_i), .alert_raw_i(alert_raw_i), .overtemp_output_raw_i(overtemp_output_raw_i),
    .fault_status_o(fault_status_o), .meas_ch_o(meas_ch_o), .meas_valid_o(meas_valid_o),
    .alert_n_o(alert_n_o), .overtemp_output_n_o(overtemp_output_n_o));

// ==== tb/rdf_host_model.sv ====
/* Two-wire host model; serial clock stands high outside frames.
 Assumes a pulled-up data line formed by the bench. */
`timescale 1ns/1ps
module rdf_host_model (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // ========================================
    // Bus conditions and bits.
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #20 sda_oe_o = !b;
        #20 scl_o = 1'b1;
        #20 r = sda_i;
        #20 scl_o = 1'b0;
    endtask
    task automatic start();
        @(negedge mclk_i) #1 sda_oe_o = 1'b0;
        #40 scl_o = 1'b1;
        #20 sda_oe_o = 1'b1;
        #20 scl_o = 1'b0;
    endtask
    task automatic stop();
        @(negedge mclk_i) #1 sda_oe_o = 1'b1;
        #40 scl_o = 1'b1;
        #20 sda_oe_o = 1'b0;
        #40;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic a_i, output logic [7:0] rx, output logic a_o);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(a_i, a_o);
    endtask
endmodule // rdf_host_model

// ==== tb/rdf_status_bench.sv ====
/* Self-checking bench for the diode-fault status block.
 Assumes rdf_status, the host model and the checker are compiled. */
`timescale 1ns/1ps
`include "rdf_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("unexpected %0t %h %h", $time, a, b); end end
module rdf_status_bench import rdf_pkg::*; ();
    // ========================================
    // Harness.
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    rdf_sense_t sense_i = '0;
    logic [5:0] alert_raw_i = 6'h00;
    logic [5:0] overtemp_output_raw_i = 6'h00;
    logic scl, host_oe, sda_o, sda_oe_o, alert_n_o, ovt_n_o, meas_valid_o, ack;
    logic [7:0] fault_status_o, rx;
    logic [2:0] meas_ch_o;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    wire sda = !(host_oe || sda_oe_o);
    always #4 mclk_i = ~mclk_i;
    rdf_status dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .sense_i(sense_i), .alert_raw_i(alert_raw_i), .overtemp_output_raw_i(overtemp_output_raw_i), .fault_status_o(fault_status_o),
        .meas_ch_o(meas_ch_o), .meas_valid_o(meas_valid_o), .alert_n_o(alert_n_o), .overtemp_output_n_o(ovt_n_o));
    rdf_host_model host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            results();
        end
    end
    task automatic wait8();
        repeat (8) @(negedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic more);
        host.start();
        host.xfer({`RDF_SLAVE_ADDR, 1'b0}, 1'b1, rx, ack);
        `CHK(ack, 1'b0)
        host.xfer(p, 1'b1, rx, ack);
        `CHK(ack, 1'b0)
        if (more) begin
            host.xfer(d, 1'b1, rx, ack);
            `CHK(ack, 1'b0)
        end
        host.stop();
        wait8();
    endtask
    task automatic rd(input logic [7:0] exp);
        wr(8'h00, 8'h00, 1'b0);
        host.start();
        host.xfer({`RDF_SLAVE_ADDR, 1'b1}, 1'b1, rx, ack);
        `CHK(ack, 1'b0)
        host.xfer(8'hFF, 1'b1, rx, ack);
        host.stop();
        `CHK(rx, exp)
        wait8();
    endtask
    // ========================================
    // Scenarios.
    task automatic t_reset();
        `CHK(({fault_status_o, alert_n_o, ovt_n_o}), ({`RDF_STATUS3_RESET, 2'b11}))
        `CHK(({sda_o, sda_oe_o}), 2'b00)
        rd(`RDF_STATUS3_RESET);
    endtask
    task automatic t_faults();
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < `RDF_NUM_CH; c++) begin
                sense_i = m ? rdf_sense_t'({6'h00, 6'h01 << c}) : rdf_sense_t'({6'h01 << c, 6'h00});
                wait8();
                `CHK(fault_status_o, ({1'b0, 6'h01 << c, 1'b0}))
            end
        sense_i = rdf_sense_t'({6'h15, 6'h00});
        wait8();
        rd(8'h2A);
    endtask
    task automatic t_addr();
        for (int b = 0; b < 7; b++) begin
            host.start();
            host.xfer({`RDF_SLAVE_ADDR ^ (7'h01 << b), 1'b1}, 1'b1, rx, ack);
            host.stop();
            `CHK(ack, 1'b1)
        end
    endtask
    task automatic t_ro();
        wr(8'h00, 8'hFF, 1'b1);
        rd(8'h2A);
    endtask
    task automatic t_mask();
        wr(8'h01, 8'h3F, 1'b1);
        wr(8'h02, 8'h3F, 1'b1);
        alert_raw_i = 6'h02;
        overtemp_output_raw_i = 6'h02;
        wait8();
        `CHK(({alert_n_o, ovt_n_o}), 2'b11)
        wr(8'h01, 8'h00, 1'b1);
        `CHK(({alert_n_o, ovt_n_o}), 2'b01)
        wr(8'h02, 8'h00, 1'b1);
        `CHK(({alert_n_o, ovt_n_o}), 2'b00)
        alert_raw_i = 6'h01;
        overtemp_output_raw_i = 6'h01;
        wait8();
        `CHK(({alert_n_o, ovt_n_o}), 2'b11)
    endtask
    task automatic t_meas();
        logic [5:0] seen = 6'h00;
        repeat (7 * `RDF_CONV_CYCLES) begin
            @(negedge mclk_i);
            if (meas_valid_o === 1'b1) seen[meas_ch_o] = 1'b1;
        end
        `CHK(seen, 6'h2A)
    endtask
    initial begin
        repeat (20) @(negedge mclk_i);
        rst_n_i = 1'b1;
        wait8();
        t_reset();
        t_faults();
        t_addr();
        t_ro();
        t_mask();
        t_meas();
        results();
    end
endmodule // rdf_status_bench
